/* core/udc_consts.svh */
`ifndef UDC_CONSTS_SVH
`define UDC_CONSTS_SVH

// ----------------------------------------
// Count range
// ----------------------------------------
`define UDC_ZERO      4'h0
`define UDC_ONE       4'h1
`define UDC_MAX_DEC   4'h9
`define UDC_MAX_BIN   4'hf

// ----------------------------------------
// Pin idle levels after reset
// ----------------------------------------
`define UDC_IDLE_UP    1'b1
`define UDC_IDLE_DOWN  1'b1
`define UDC_IDLE_LOAD  1'b1
`define UDC_IDLE_CLEAR 1'b0
`define UDC_IDLE_DATA  1'b0

// ----------------------------------------
// Synchroniser layout
// ----------------------------------------
`define UDC_NUM_PINS   8
`define UDC_PIN_UP     4
`define UDC_PIN_DOWN   5
`define UDC_PIN_LOAD   6
`define UDC_PIN_CLEAR  7

`endif

/* core/udc_pkg.sv */
package udc_pkg;
	typedef logic [3:0] udc_count_t;
endpackage

/* core/udc_sync.sv */
`timescale 1ns/100ps
module udc_sync
	import udc_pkg::*;
#(
	parameter bit RST_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic pin,
	output logic      level
);
	logic s1_r, s2_r, s3_r, level_r;
	logic level_nxt;

	// Level moves only when the second and third stages agree
	always_comb begin
		level_nxt = level_r;
		if (s2_r == s3_r) begin
			level_nxt = s3_r;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_r    <= RST_VAL;
			s2_r    <= RST_VAL;
			s3_r    <= RST_VAL;
			level_r <= RST_VAL;
		end else begin
			s1_r    <= pin;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			level_r <= level_nxt;
		end
	end

	assign level = level_r;
endmodule

/* core/udc_counter.sv */
`timescale 1ns/100ps
`include "udc_consts.svh"

// What this block does
// [R1] All count bits update on one count edge
// [R2] Up edge increments, down edge decrements
// [R3] Load low makes outputs follow data
// [R4] Clear high forces zero, overrides everything
// [R5] Borrow low at zero while down low
// [R6] Carry low at maximum while up low
// [R7] Carry/borrow drive next stage's up/down
// [R8] Decade wraps nine-zero, both directions
// [R9] Binary wraps fifteen-zero, both directions
// [R10] Decade counts down zero, nine, eight, seven
// [R11] Driver holds opposite count input high
// [R12] Decade or binary sequence, four bits
// [R13] Synchronous update, no ripple between bits
// [R14] Parameter selects decade or binary variant
module udc_counter
	import udc_pkg::*;
#(
	parameter bit DECADE = 1'b1
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       count_up,
	input  wire logic       count_down,
	input  wire logic       load_n,
	input  wire logic       clear,
	input  wire logic [3:0] data,
	output logic      [3:0] q,
	output logic            carry_out_n,
	output logic            borrow_out_n
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam udc_count_t TERM = DECADE ? `UDC_MAX_DEC : `UDC_MAX_BIN; // [R14] [R12]
	localparam logic [`UDC_NUM_PINS-1:0] IDLE = {`UDC_IDLE_CLEAR, `UDC_IDLE_LOAD,
		`UDC_IDLE_DOWN, `UDC_IDLE_UP, {4{`UDC_IDLE_DATA}}};

	logic [`UDC_NUM_PINS-1:0] raw, filt;
	assign raw = {clear, load_n, count_down, count_up, data};

	genvar gi;
	generate
		for (gi = 0; gi < `UDC_NUM_PINS; gi++) begin : g_sync
			udc_sync #(.RST_VAL(IDLE[gi])) u_sync (
				.clk   (clk),
				.reset (reset),
				.pin   (raw[gi]),
				.level (filt[gi])
			);
		end
	endgenerate

	logic       up_f, down_f, load_f, clear_f;
	udc_count_t data_f;
	assign up_f    = filt[`UDC_PIN_UP];
	assign down_f  = filt[`UDC_PIN_DOWN];
	assign load_f  = filt[`UDC_PIN_LOAD];
	assign clear_f = filt[`UDC_PIN_CLEAR];
	assign data_f  = filt[3:0];

	// ----------------------------------------
	// Shared decodes
	// ----------------------------------------
	function automatic logic at_top(input udc_count_t v);
		return v == TERM;
	endfunction

	function automatic logic at_zero(input udc_count_t v);
		return v == `UDC_ZERO;
	endfunction

	// ----------------------------------------
	// Edge detectors
	// ----------------------------------------
	// Reset to the idle high level, so release shows no false edge
	logic up_q_r, up_q_nxt, down_q_r, down_q_nxt;
	logic up_rise, down_rise;

	always_comb begin
		up_q_nxt   = up_f;
		down_q_nxt = down_f;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			up_q_r   <= `UDC_IDLE_UP;
			down_q_r <= `UDC_IDLE_DOWN;
		end else begin
			up_q_r   <= up_q_nxt;
			down_q_r <= down_q_nxt;
		end
	end

	assign up_rise   = up_f & ~up_q_r;
	assign down_rise = down_f & ~down_q_r;

	// ----------------------------------------
	// Count state
	// ----------------------------------------
	// Load and clear ride the synchronisers as well, so they act
	// five cycles late rather than at once; one clock, no races
	udc_count_t q_r, q_nxt;

	always_comb begin
		q_nxt = q_r;
		if (clear_f) begin
			q_nxt = `UDC_ZERO; // [R4]
		end else if (!load_f) begin
			q_nxt = data_f; // [R3]
		end else if (up_rise && down_f && !down_rise) begin
			// Out-of-range decade loads also step to zero past the top
			q_nxt = (q_r >= TERM) ? `UDC_ZERO : q_r + `UDC_ONE; // [R1] [R2] [R8] [R9] [R13]
		end else if (down_rise && up_f && !up_rise) begin
			// Both edges at once is illegal; held instead of guessing
			q_nxt = at_zero(q_r) ? TERM : q_r - `UDC_ONE; // [R2] [R8] [R9] [R10] [R11]
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q_r <= `UDC_ZERO;
		end else begin
			q_r <= q_nxt;
		end
	end

	// ----------------------------------------
	// Cascade flags
	// ----------------------------------------
	// Judged on the next count so the flags move with q, not after it
	logic carry_r, carry_nxt, borrow_r, borrow_nxt;

	always_comb begin
		carry_nxt  = ~(at_top(q_nxt) && !up_f); // [R6] [R7]
		borrow_nxt = ~(at_zero(q_nxt) && !down_f); // [R5] [R7]
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			carry_r  <= 1'b1;
			borrow_r <= 1'b1;
		end else begin
			carry_r  <= carry_nxt;
			borrow_r <= borrow_nxt;
		end
	end

	assign q            = q_r;
	assign carry_out_n  = carry_r;
	assign borrow_out_n = borrow_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_clear_forces_zero: assert property (@(posedge clk) disable iff (reset) // [R4]
		clear_f |=> (q_r == `UDC_ZERO))
		else $error("clear did not force zero");

	chk_clear_over_load: assert property (@(posedge clk) disable iff (reset) // [R4]
		(clear_f && !load_f) |=> at_zero(q_r))
		else $error("load won over clear");

	chk_load_follows_data: assert property (@(posedge clk) disable iff (reset) // [R3]
		(!clear_f && !load_f) |=> (q_r == $past(data_f)))
		else $error("load did not copy data");

	chk_up_increment: assert property (@(posedge clk) disable iff (reset) // [R2]
		(!clear_f && load_f && up_rise && down_f && !down_rise && q_r < TERM)
		|=> (q_r == $past(q_r) + `UDC_ONE))
		else $error("count up did not increment");

	chk_up_wrap_zero: assert property (@(posedge clk) disable iff (reset) // [R8] [R9]
		(!clear_f && load_f && up_rise && down_f && !down_rise && at_top(q_r))
		|=> (q_r == `UDC_ZERO))
		else $error("count up did not wrap to zero");

	// Decade loads above nine step to zero, never on to ten
	chk_over_top_zero: assert property (@(posedge clk) disable iff (reset) // [R8]
		(!clear_f && load_f && up_rise && down_f && !down_rise && q_r > TERM)
		|=> at_zero(q_r))
		else $error("out of range count did not go to zero");

	chk_down_decrement: assert property (@(posedge clk) disable iff (reset) // [R2]
		(!clear_f && load_f && down_rise && up_f && !up_rise && !at_zero(q_r))
		|=> (q_r == $past(q_r) - `UDC_ONE))
		else $error("count down did not decrement");

	chk_down_wrap_term: assert property (@(posedge clk) disable iff (reset) // [R10]
		(!clear_f && load_f && down_rise && up_f && !up_rise && q_r == `UDC_ZERO)
		|=> (q_r == TERM))
		else $error("count down did not wrap to terminal");

	chk_idle_holds: assert property (@(posedge clk) disable iff (reset) // [R1] [R13]
		(!clear_f && load_f && !up_rise && !down_rise) |=> $stable(q_r))
		else $error("count moved without an edge");

	chk_borrow_level: assert property (@(posedge clk) disable iff (reset) // [R5]
		1'b1 |=> (borrow_r == !(q_r == `UDC_ZERO && !$past(down_f))))
		else $error("borrow out wrong");

	chk_carry_level: assert property (@(posedge clk) disable iff (reset) // [R6]
		1'b1 |=> (carry_r == !(q_r == TERM && !$past(up_f))))
		else $error("carry out wrong");

	chk_borrow_idle_high: assert property (@(posedge clk) disable iff (reset) // [R5]
		down_f |=> borrow_r)
		else $error("borrow low while count down high");

	chk_carry_idle_high: assert property (@(posedge clk) disable iff (reset) // [R6]
		up_f |=> carry_r)
		else $error("carry low while count up high");

	// The counting antecedents above exclude a second edge, so the hold is judged here

	chk_both_edges_hold: assert property (@(posedge clk) disable iff (reset) // [R11]
		(!clear_f && load_f && up_rise && down_rise) |=> $stable(q_r))
		else $error("simultaneous edges changed count");
endmodule

/* verif/udc_drv.sv */
`timescale 1ns/100ps
module udc_drv (
	input  wire logic clk,
	output logic      up,
	output logic      down
);
	initial begin
		up = 1'b1;
		down = 1'b1;
	end

	// Only one line moves, the other idles high
	task automatic set(input bit dir_up, input bit v);
		@(posedge clk);
		#1;
		if (dir_up) up = v;
		else down = v;
	endtask
endmodule

/* verif/tb.sv */
`timescale 1ns/100ps
module tb
	import udc_pkg::*;
;
	logic       clk = 1'b0;
	logic       reset = 1'b1;
	logic       load_n = 1'b1;
	logic       clear = 1'b0;
	logic [3:0] data = 4'h0;
	logic       up;
	logic       down;
	udc_count_t qd;
	udc_count_t qb;
	logic       cd_n, bd_n, cb_n, bb_n;
	udc_count_t qh;
	logic       ch_n, bh_n;
	int         failures = 0;
	int         checks_done = 0;
	int         cyc = 0;
	int         md, mb;

	always #5 clk = ~clk;
	// Far beyond the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			end_sim();
		end
	end

	udc_drv i_drv (.clk(clk), .up(up), .down(down));
	udc_counter #(.DECADE(1'b1)) i_dut (.clk(clk), .reset(reset), .count_up(up),
		.count_down(down), .load_n(load_n), .clear(clear), .data(data), .q(qd),
		.carry_out_n(cd_n), .borrow_out_n(bd_n));
	udc_counter #(.DECADE(1'b0)) i_dut_bin (.clk(clk), .reset(reset), .count_up(up),
		.count_down(down), .load_n(load_n), .clear(clear), .data(data), .q(qb),
		.carry_out_n(cb_n), .borrow_out_n(bb_n));
	// Upper decade stage counts only on the lower stage's flags
	udc_counter #(.DECADE(1'b1)) i_dut_hi (.clk(clk), .reset(reset), .count_up(cd_n),
		.count_down(bd_n), .load_n(load_n), .clear(clear), .data(data), .q(qh),
		.carry_out_n(ch_n), .borrow_out_n(bh_n));

	task automatic check(input string n, input logic [3:0] s, input logic [3:0] e);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic end_sim();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic preset(input logic [3:0] v);
		load_n = 1'b0;
		data = v;
		wait_n(6);
		check("load_q", qd, v);
		load_n = 1'b1;
		wait_n(6);
		md = v;
		mb = v;
	endtask

	// Flags judged mid low phase, count after the rise
	task automatic tick(input bit u);
		i_drv.set(u, 1'b0);
		wait_n(8);
		check("dec_flag", {3'h0, u ? cd_n : bd_n}, {3'h0, md != (u ? 9 : 0)});
		check("bin_flag", {3'h0, u ? cb_n : bb_n}, {3'h0, mb != (u ? 15 : 0)});
		i_drv.set(u, 1'b1);
		wait_n(8);
		md = u ? (md >= 9 ? 0 : md + 1) : (md == 0 ? 9 : md - 1);
		mb = (u ? mb + 1 : mb - 1) & 15;
		check("dec_q", qd, 4'(md));
		check("bin_q", qb, 4'(mb));
	endtask

	task automatic t_clear();
		load_n = 1'b0;
		data = 4'h5;
		clear = 1'b1;
		wait_n(6);
		check("clr_q", qd, 4'h0);
		clear = 1'b0;
		wait_n(6);
		check("load_q", qb, 4'h5);
		load_n = 1'b1;
		wait_n(6);
	endtask

	task automatic t_up();
		preset(4'h7);
		repeat (5) tick(1'b1);
	endtask

	task automatic t_down();
		repeat (5) tick(1'b0);
	endtask

	task automatic t_bin_wrap();
		preset(4'he);
		repeat (2) tick(1'b1);
	endtask

	// Upper stage flag still low when tick returns, count lands 2 cycles later
	task automatic t_cascade();
		preset(4'h9);
		tick(1'b1);
		check("hi_carry", {3'h0, ch_n}, 4'h0);
		wait_n(4);
		check("hi_up_q", qh, 4'h0);
		check("hi_carry", {3'h0, ch_n}, 4'h1);
		tick(1'b0);
		check("hi_borrow", {3'h0, bh_n}, 4'h0);
		wait_n(4);
		check("hi_dn_q", qh, 4'h9);
		check("hi_borrow", {3'h0, bh_n}, 4'h1);
	endtask

	initial begin
		wait_n(6);
		reset = 1'b0;
		wait_n(1);
		t_clear();
		t_up();
		t_down();
		t_bin_wrap();
		t_cascade();
		end_sim();
	end
endmodule
